/* File: tecds_supervisor.sv */
// thermoelectric cooler drive supervisor: ranging, slew, protection
// Operation
// - excitation choices 1mA, 100uA, 10uA, auto
// - auto picks current from sensor resistance
// - overlapping ranges keep previous excitation
// - semiconductor sensor in auto uses 1mA
// - slew limit 0..1000 A/s, reset 100
// - every new target ramps at slew limit
// - drive updates once per conversion tick
// - disable drops drive to zero at once
// - re-enable ramps back to previous target
// - voltage over ceiling above one second cuts
// - first overvoltage cut raises fault once
// - stays off until target zero or toggle
// - clamp target, low limit wins conflicts
// - disabled outputs hold zero despite low limit
`default_nettype none
module tecds_supervisor #(
  parameter int CONV_MS     = tecds_pkg::CONV_INTERVAL_MS,
  parameter int OV_HOLD_CYC = tecds_pkg::OV_HOLD_MS
                              * (tecds_pkg::NS_PER_MS
                              / tecds_pkg::CLK_PERIOD_NS)
) (
  input  wire logic                                   core_clk_i,
  input  wire logic                                   sys_rst_i,
  input  wire logic                                   conv_tick_i,
  input  wire tecds_pkg::tecds_exc_mode_type          exc_mode_i,
  input  wire logic                                   sensor_is_semi_i,
  input  wire logic [tecds_pkg::RES_W-1:0]            sensor_res_i,
  input  wire logic                                   slew_wr_i,
  input  wire logic [tecds_pkg::SLEW_W-1:0]           slew_rate_i,
  input  wire logic                                   target_wr_i,
  input  wire logic signed [tecds_pkg::DRIVE_W-1:0]   target_i,
  input  wire tecds_pkg::tecds_limits_type            limits_i,
  input  wire logic                                   outputs_allowed_i,
  input  wire logic signed [tecds_pkg::VOLT_W-1:0]    cooler_volt_i,
  input  wire logic signed [tecds_pkg::VOLT_W-1:0]    volt_ceiling_i,
  output var  logic signed [tecds_pkg::DRIVE_W-1:0]   drive_o,
  output var  tecds_pkg::tecds_range_type             exc_sel_o,
  output var  logic [tecds_pkg::SLEW_W-1:0]           slew_limit_o,
  output var  logic                                   ov_shutdown_o,
  output var  logic                                   hw_fault_o
);
  import tecds_pkg::*;

  localparam int CW = $clog2(OV_HOLD_CYC + 1);
  localparam logic [CW-1:0] OV_LAST = CW'(OV_HOLD_CYC);

  // =========================================================
  // excitation auto ranging
  tecds_range_type rng_r, rng_nxt;

  // overlap bands keep the present range, so no chatter
  always_comb begin
    rng_nxt = rng_r;
    case (exc_mode_i)
      EXC_FIX_1MA:   rng_nxt = RNG_1MA;
      EXC_FIX_100UA: rng_nxt = RNG_100UA;
      EXC_FIX_10UA:  rng_nxt = RNG_10UA;
      default: begin
        if (sensor_is_semi_i) begin
          rng_nxt = RNG_1MA;
        end else if (sensor_res_i < RES_MID_FLOOR) begin
          rng_nxt = RNG_1MA;
        end else if (sensor_res_i > RES_MID_CEIL) begin
          rng_nxt = RNG_10UA;
        end else begin
          case (rng_r)
            RNG_1MA: begin
              if (sensor_res_i >= RES_HI_CEIL) begin
                rng_nxt = RNG_100UA;
              end
            end
            RNG_10UA: begin
              if (sensor_res_i <= RES_LO_FLOOR) begin
                rng_nxt = RNG_100UA;
              end
            end
            default: rng_nxt = RNG_100UA;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rng_r <= RNG_1MA;
    end else begin
      rng_r <= rng_nxt;
    end
  end

  // =========================================================
  // slew limit and target registers
  logic [SLEW_W-1:0]        slew_r, slew_nxt;
  logic signed [DRIVE_W-1:0] tgt_r, tgt_nxt;

  // oversize writes saturate rather than wrap
  always_comb begin
    slew_nxt = slew_r;
    tgt_nxt  = tgt_r;
    if (slew_wr_i) begin
      slew_nxt = (slew_rate_i > SLEW_MAX_APS) ? SLEW_MAX_APS
                                              : slew_rate_i;
    end
    if (target_wr_i) begin
      tgt_nxt = target_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      slew_r <= SLEW_RST_APS;
      tgt_r  <= '0;
    end else begin
      slew_r <= slew_nxt;
      tgt_r  <= tgt_nxt;
    end
  end

  // =========================================================
  // overvoltage watch
  logic          above;
  logic          ov_trip;
  logic          ov_clear;
  logic [CW-1:0] ov_cnt_r, ov_cnt_nxt;
  logic          ov_r, ov_nxt;
  logic          seen_r, seen_nxt;
  logic          fault_r, fault_nxt;

  // trip fires one cycle after the full second has elapsed
  always_comb begin
    above      = cooler_volt_i > volt_ceiling_i;
    ov_cnt_nxt = '0;
    if (above) begin
      ov_cnt_nxt = (ov_cnt_r == OV_LAST) ? ov_cnt_r
                                         : ov_cnt_r + 1'b1;
    end
    ov_trip  = above && (ov_cnt_r == OV_LAST) && !ov_r;
    ov_clear = (target_wr_i && (target_i == '0))
               || !outputs_allowed_i;
    ov_nxt    = ov_trip || (ov_r && !ov_clear);
    seen_nxt  = seen_r || ov_trip;
    fault_nxt = ov_trip && !seen_r;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ov_cnt_r <= '0;
      ov_r     <= 1'b0;
      seen_r   <= 1'b0;
      fault_r  <= 1'b0;
    end else begin
      ov_cnt_r <= ov_cnt_nxt;
      ov_r     <= ov_nxt;
      seen_r   <= seen_nxt;
      fault_r  <= fault_nxt;
    end
  end

  // =========================================================
  // clamped goal and slew-limited drive
  logic signed [DRIVE_W-1:0] goal;
  logic signed [DRIVE_W:0]   diff;
  logic [DRIVE_W:0]          mag;
  logic [STEP_W-1:0]         step;
  logic signed [DRIVE_W-1:0] drive_r, drive_nxt;
  logic signed [DRIVE_W-1:0] drive_prev_r;  // last drive, for checks

  // high clamp first so the low limit has the last word
  always_comb begin
    goal = tgt_r;
    if (goal > limits_i.high_output_limit) begin
      goal = limits_i.high_output_limit;
    end
    if (goal < limits_i.low_output_limit) begin
      goal = limits_i.low_output_limit;
    end
    diff = {goal[DRIVE_W-1], goal} - {drive_r[DRIVE_W-1], drive_r};
    mag  = diff[DRIVE_W] ? (DRIVE_W+1)'(-diff) : diff;
    step = STEP_W'(slew_r) * STEP_W'(CONV_MS);
    drive_nxt = drive_r;
    if (!outputs_allowed_i || ov_r || ov_trip) begin
      drive_nxt = '0;
    end else if (conv_tick_i) begin
      if (step >= STEP_W'(mag)) begin
        drive_nxt = goal;
      end else if (diff[DRIVE_W]) begin
        drive_nxt = drive_r - DRIVE_W'(step);
      end else begin
        drive_nxt = drive_r + DRIVE_W'(step);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      drive_r      <= '0;
      drive_prev_r <= '0;
    end else begin
      drive_r      <= drive_nxt;
      drive_prev_r <= drive_r;
    end
  end

  // =========================================================
  // outputs, all straight from flops
  always_comb begin
    drive_o       = drive_r;
    exc_sel_o     = rng_r;
    slew_limit_o  = slew_r;
    ov_shutdown_o = ov_r;
    hw_fault_o    = fault_r;
  end

  // =========================================================
  // assertions
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // movement across the last edge, taken from the kept previous drive
  logic signed [DRIVE_W:0] moved;
  always_comb begin
    moved = {drive_r[DRIVE_W-1], drive_r}
            - {drive_prev_r[DRIVE_W-1], drive_prev_r};
  end

  a_disable_zero: assert property (
    !outputs_allowed_i |=> drive_o == '0)
    else $error("drive not zero after disable");

  a_hold_no_tick: assert property (
    (!conv_tick_i && outputs_allowed_i && !ov_r && !ov_trip)
    |=> $stable(drive_o))
    else $error("drive moved without a tick");

  a_slew_bound: assert property (
    (conv_tick_i && outputs_allowed_i && !ov_r && !ov_trip)
    |=> ((moved[DRIVE_W] ? STEP_W'(-moved) : STEP_W'(moved))
         <= $past(step)))
    else $error("drive step above slew limit");

  a_zero_slew_hold: assert property (
    (conv_tick_i && slew_r == '0 && outputs_allowed_i && !ov_r
     && !ov_trip)
    |=> $stable(drive_o))
    else $error("zero slew did not hold drive");

  a_ov_cut: assert property (
    $rose(ov_shutdown_o) |-> drive_o == '0
    && $past(ov_cnt_r) == OV_LAST && $past(above))
    else $error("overvoltage cut not timed or not off");

  a_ov_latch: assert property (
    (ov_r && !ov_clear) |=> ov_r && drive_o == '0)
    else $error("drive resumed before zero target");

  a_fault_first: assert property (
    hw_fault_o |-> $rose(ov_shutdown_o) && !$past(seen_r))
    else $error("fault raised outside first cut");

  a_fault_once: assert property (
    $past(seen_r) |-> !hw_fault_o)
    else $error("fault raised twice");

  a_semi_high: assert property (
    (exc_mode_i == EXC_AUTO && sensor_is_semi_i)
    |=> exc_sel_o == RNG_1MA)
    else $error("semiconductor sensor not at 1mA");

  a_hyst_keep: assert property (
    (exc_mode_i == EXC_AUTO && !sensor_is_semi_i
     && sensor_res_i >= RES_MID_FLOOR && sensor_res_i < RES_HI_CEIL
     && rng_r == RNG_1MA) |=> exc_sel_o == RNG_1MA)
    else $error("range switched inside overlap");

  a_clamp_low: assert property (
    goal >= limits_i.low_output_limit)
    else $error("goal below low limit");

  a_slew_max: assert property (
    slew_limit_o <= SLEW_MAX_APS)
    else $error("slew limit above maximum");

  a_clamp_high: assert property (
    (limits_i.high_output_limit >= limits_i.low_output_limit)
    |-> goal <= limits_i.high_output_limit)
    else $error("goal above high limit");

  a_exc_fixed: assert property (
    (exc_mode_i == EXC_FIX_10UA) |=> exc_sel_o == RNG_10UA)
    else $error("fixed excitation not applied");

  c_ov_cut: cover property ($rose(ov_shutdown_o));
  c_reenable: cover property (
    !outputs_allowed_i ##1 outputs_allowed_i ##[1:20]
    (conv_tick_i && drive_o != '0));
  c_to_low: cover property ($rose(exc_sel_o == RNG_10UA));
  c_ramp: cover property (conv_tick_i && step < STEP_W'(mag));

endmodule : tecds_supervisor
`default_nettype wire

/* File: tecds_pkg.sv */
// constants and types for the thermoelectric cooler drive supervisor
`default_nettype none
package tecds_pkg;

  // =========================================================
  // widths
  localparam int DRIVE_W = 20;  // drive current in mA, signed
  localparam int RES_W   = 24;  // sensor resistance in ohms
  localparam int VOLT_W  = 16;  // cooler voltage in mV, signed
  localparam int SLEW_W  = 10;  // slew limit in A/s
  localparam int STEP_W  = 32;  // slew step product width

  // =========================================================
  // slew limit
  localparam logic [SLEW_W-1:0] SLEW_MAX_APS = 10'h3E8;  // 1000 A/s
  localparam logic [SLEW_W-1:0] SLEW_RST_APS = 10'h064;  // 100 A/s
  localparam int CONV_INTERVAL_MS = 100;  // conversion tick spacing

  // =========================================================
  // auto range thresholds in ohms
  localparam logic [RES_W-1:0] RES_MID_FLOOR = 24'h0003E8;  // 1 kohm
  localparam logic [RES_W-1:0] RES_HI_CEIL   = 24'h0007D0;  // 2 kohm
  localparam logic [RES_W-1:0] RES_LO_FLOOR  = 24'h002710;  // 10 kohm
  localparam logic [RES_W-1:0] RES_MID_CEIL  = 24'h004E20;  // 20 kohm

  // =========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OV_HOLD_MS    = 1000;  // overvoltage persistence
  localparam int NS_PER_MS     = 1000000;

  // =========================================================
  // types
  typedef enum logic [1:0] {
    EXC_FIX_1MA   = 2'h0,
    EXC_FIX_100UA = 2'h1,
    EXC_FIX_10UA  = 2'h2,
    EXC_AUTO      = 2'h3
  } tecds_exc_mode_type;

  typedef enum logic [2:0] {
    RNG_1MA   = 3'h1,
    RNG_100UA = 3'h2,
    RNG_10UA  = 3'h4
  } tecds_range_type;

  typedef struct packed {
    logic signed [DRIVE_W-1:0] high_output_limit;
    logic signed [DRIVE_W-1:0] low_output_limit;
  } tecds_limits_type;

endpackage : tecds_pkg
`default_nettype wire

/* File: tecds_cooler_model.sv */
// behavioural cooler and thermistor facing the drive supervisor
`default_nettype none
module tecds_cooler_model (
  input  wire logic                                 surge_i,
  input  wire logic signed [tecds_pkg::DRIVE_W-1:0] drive_i,
  input  wire logic [tecds_pkg::RES_W-1:0]          res_set_i,
  output var  logic signed [tecds_pkg::VOLT_W-1:0]  volt_o,
  output var  logic [tecds_pkg::RES_W-1:0]          res_o
);
  import tecds_pkg::*;
  // =======================================================
  // cooler as half an ohm; surge stands for a failing element
  always_comb begin
    volt_o = VOLT_W'(drive_i >>> 1) + (surge_i ? 16'sh4000 : 16'sh0000);
    res_o  = res_set_i;  // sensor reading follows the bench setting
  end
endmodule : tecds_cooler_model
`default_nettype wire

/* File: tec_drive_supervisor_tb_top.sv */
// self-checking bench for the drive supervisor
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
  $display("Error t=%0t got %h want %h", $time, a, b); end end
module tec_drive_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tecds_pkg::*;
  logic                      clk = 0, rst = 1, tick = 0, semi = 0;
  logic                      swr = 0, twr = 0, allowed = 1, surge = 0;
  tecds_exc_mode_type        mode = EXC_AUTO;
  logic [RES_W-1:0]          res = 24'h0001F4;
  logic [SLEW_W-1:0]         slew = 10'h000;
  logic signed [DRIVE_W-1:0] tgt = 20'sh00000;
  tecds_limits_type          lim = '{20'sh7FFFF, 20'sh80000};
  logic signed [VOLT_W-1:0]  volt;
  logic signed [VOLT_W-1:0]  ceil = 16'sh4000;
  logic [RES_W-1:0]          sres;
  logic signed [DRIVE_W-1:0] drv;
  tecds_range_type           exc;
  logic [SLEW_W-1:0]         slim;
  logic                      ovs, hwf;
  int miscompares = 0, compares = 0, cyc = 0, faults = 0;

  // =======================================================
  // clock, fault pulse count and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (hwf === 1'b1) faults++;
    if (cyc == 3000) begin
      miscompares++;
      give_verdict();
    end
  end

  tecds_supervisor #(.OV_HOLD_CYC(20)) DUT (
    .core_clk_i(clk), .sys_rst_i(rst), .conv_tick_i(tick),
    .exc_mode_i(mode), .sensor_is_semi_i(semi), .sensor_res_i(sres),
    .slew_wr_i(swr), .slew_rate_i(slew), .target_wr_i(twr),
    .target_i(tgt), .limits_i(lim), .outputs_allowed_i(allowed),
    .cooler_volt_i(volt), .volt_ceiling_i(ceil), .drive_o(drv),
    .exc_sel_o(exc), .slew_limit_o(slim), .ov_shutdown_o(ovs),
    .hw_fault_o(hwf));
  tecds_cooler_model partner (.surge_i(surge), .drive_i(drv),
    .res_set_i(res), .volt_o(volt), .res_o(sres));

  // =======================================================
  // bus-less strobes: raise after an edge, drop after the next
  task automatic wr_tgt(input logic signed [DRIVE_W-1:0] v);
    @(posedge clk) begin twr <= 1'b1; tgt <= v; end
    @(posedge clk) twr <= 1'b0;
  endtask : wr_tgt
  task automatic wr_slew(input logic [SLEW_W-1:0] v, e);
    @(posedge clk) begin swr <= 1'b1; slew <= v; end
    @(posedge clk) swr <= 1'b0;
    #1 `CHK(slim, e)
  endtask : wr_slew
  task automatic tick_chk(input logic signed [DRIVE_W-1:0] e);
    @(posedge clk) tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
    #1 `CHK(drv, e)
  endtask : tick_chk
  task automatic exc_chk(input tecds_exc_mode_type m, input logic s,
                         input logic [RES_W-1:0] r, input tecds_range_type e);
    @(posedge clk) begin mode <= m; semi <= s; res <= r; end
    @(posedge clk);
    #1 `CHK(exc, e)
  endtask : exc_chk
  // surge held until the latch shows; trip must come one cycle past hold
  task automatic trip(input logic f);
    int n;
    n = 0;
    @(posedge clk) surge <= 1'b1;
    do begin
      @(posedge clk);
      #1 n++;
    end while (ovs !== 1'b1 && n < 40);
    `CHK(n, 21)
    `CHK(drv, 20'sh00000)
    `CHK(hwf, f)
    @(posedge clk) surge <= 1'b0;
  endtask : trip

  // =======================================================
  // scenarios
  task automatic t_reset();
    @(posedge clk);
    #1 `CHK(drv, 20'sh00000)
    `CHK(exc, RNG_1MA)
    `CHK(slim, SLEW_RST_APS)
    `CHK({ovs, hwf}, 2'h0)
  endtask : t_reset
  task automatic t_ramp();
    wr_tgt(20'sh03A98);
    tick_chk(20'sh02710);
    tick_chk(20'sh03A98);
    wr_tgt(-20'sh03A98);
    tick_chk(20'sh01388);
    tick_chk(-20'sh01388);
    tick_chk(-20'sh03A98);
    wr_slew(10'h000, 10'h000);
    wr_tgt(20'sh00000);
    tick_chk(-20'sh03A98);
    wr_slew(10'h3FF, SLEW_MAX_APS);
    tick_chk(20'sh00000);
  endtask : t_ramp
  task automatic t_clamp();
    @(posedge clk) lim <= '{20'sh00BB8, 20'sh003E8};
    wr_tgt(20'sh01388);
    tick_chk(20'sh00BB8);
    @(posedge clk) lim <= '{20'sh001F4, 20'sh003E8};
    tick_chk(20'sh003E8);
  endtask : t_clamp
  task automatic t_enable();
    @(posedge clk) allowed <= 1'b0;
    @(posedge clk);
    #1 `CHK(drv, 20'sh00000)
    tick_chk(20'sh00000);
    wr_slew(10'h00A, 10'h00A);
    @(posedge clk) begin
      lim     <= '{20'sh00BB8, 20'sh00000};
      allowed <= 1'b1;
    end
    tick_chk(20'sh003E8);
    tick_chk(20'sh007D0);
    tick_chk(20'sh00BB8);
  endtask : t_enable
  task automatic t_exc();
    exc_chk(EXC_FIX_100UA, 1'b0, 24'h0001F4, RNG_100UA);
    exc_chk(EXC_FIX_10UA, 1'b0, 24'h0001F4, RNG_10UA);
    exc_chk(EXC_FIX_1MA, 1'b0, 24'h0061A8, RNG_1MA);
    exc_chk(EXC_AUTO, 1'b0, 24'h0061A8, RNG_10UA);
    exc_chk(EXC_AUTO, 1'b0, 24'h003A98, RNG_10UA);
    exc_chk(EXC_AUTO, 1'b0, 24'h002710, RNG_100UA);
    exc_chk(EXC_AUTO, 1'b0, 24'h0005DC, RNG_100UA);
    exc_chk(EXC_AUTO, 1'b0, 24'h0003E7, RNG_1MA);
    exc_chk(EXC_AUTO, 1'b0, 24'h0005DC, RNG_1MA);
    exc_chk(EXC_AUTO, 1'b0, 24'h0007D0, RNG_100UA);
    exc_chk(EXC_AUTO, 1'b1, 24'h0061A8, RNG_1MA);
  endtask : t_exc
  task automatic t_ov();
    wr_slew(10'h064, 10'h064);
    trip(1'b1);
    tick_chk(20'sh00000);
    wr_tgt(20'sh00000);
    wr_tgt(20'sh00BB8);
    tick_chk(20'sh00BB8);
    trip(1'b0);
    `CHK(faults, 1)
    @(posedge clk) allowed <= 1'b0;
    @(posedge clk) allowed <= 1'b1;
    tick_chk(20'sh00BB8);
  endtask : t_ov

  task automatic give_verdict();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ramp();
    t_clamp();
    t_enable();
    t_exc();
    t_ov();
    give_verdict();
  end
endmodule : tec_drive_supervisor_tb_top
`default_nettype wire
